// File: logic/psq_sequencer.sv
// Power-on reset sequencer with strap capture, reset flows and an AXI4-Lite slave.
// Assumes all pin inputs are synchronous to clock and the hard reset wire is resolved outside.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "psq_cfg.svh"

// Summary of operation
// RL1: Power-on reset assertion restarts the flow and resets the config, cause and control registers.
// RL2: Outside supervisor holds power-on reset low at least 16 clock cycles.
// RL3: Boot mode, watchdog, byte width and strobe polarity straps latch at release.
// RL4: Hard reset output releases 522 clock cycles after power-on reset release.
// RL5: Reset configuration is taken from the host port or the I2C loader.
// RL6: Power-on reset drives hard reset and resets PLL, core and peripherals.
// RL7: Configuration is sampled only in power-on reset, never in hard or soft reset.
// RL8: Hard reset pin starts a hard flow and is driven open-drain while asserted.
// RL9: A status register records which sources caused the most recent reset.
// RL10: Release counter restarts whenever power-on reset is asserted again early.
module psq_sequencer (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic power_on_reset_n,
    input wire psq_pkg::psq_straps_t strap_pins,
    input wire logic hard_reset_in,
    output logic hard_reset_out,
    output logic hard_reset_oe,
    input wire logic watchdog_expired,
    input wire logic bus_monitor_expired,
    input wire logic jtag_soft_req,
    input wire logic host_cfg_valid,
    input wire logic [15:0] host_cfg_word,
    input wire logic i2c_cfg_valid,
    input wire logic [15:0] i2c_cfg_word,
    output logic pll_reset_n,
    output logic core_reset_n,
    output logic periph_reset_n,
    output logic soft_reset_n,
    output psq_pkg::psq_straps_t boot_straps,
    output logic [15:0] reset_config,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Maps a byte address to a register index; index 7 means unmapped.
    function automatic logic [2:0] psq_reg_sel(input logic [7:0] addr);
        case (addr)
            `PSQ_REG_CAUSE: psq_reg_sel = 3'h0;
            `PSQ_REG_STRAPS: psq_reg_sel = 3'h1;
            `PSQ_REG_CONFIG: psq_reg_sel = 3'h2;
            `PSQ_REG_CONTROL: psq_reg_sel = 3'h3;
            `PSQ_REG_STATE: psq_reg_sel = 3'h4;
            default: psq_reg_sel = 3'h7;
        endcase
    endfunction

    psq_pkg::psq_state_t state;
    psq_pkg::psq_state_t next_state;
    psq_pkg::psq_cause_t cause;
    psq_pkg::psq_cause_t cause_set;
    logic [1:0] control;
    logic cfg_from_host;
    logic cfg_from_i2c;
    logic at_last;
    logic [`PSQ_CNT_W-1:0] limit;
    logic hard_trig;
    logic soft_trig;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic [2:0] wr_sel;
    logic wr_low;

    // The pin is only read while the sequencer itself is not pulling it low.
    assign hard_trig = watchdog_expired | bus_monitor_expired | ~hard_reset_in
        | control[`PSQ_CTRL_HARD_BIT]; // RL8
    assign soft_trig = jtag_soft_req | control[`PSQ_CTRL_SOFT_BIT];

    always_comb begin
        next_state = state;
        if (!power_on_reset_n) begin
            next_state = psq_pkg::PSQ_POR_HOLD; // RL1
        end else begin
            case (state)
                psq_pkg::PSQ_POR_HOLD: next_state = psq_pkg::PSQ_POR_WAIT;
                psq_pkg::PSQ_POR_WAIT: begin
                    if (at_last) begin
                        next_state = psq_pkg::PSQ_RUN; // RL4
                    end
                end
                psq_pkg::PSQ_RUN: begin
                    if (hard_trig) begin
                        next_state = psq_pkg::PSQ_HARD_HOLD; // RL8
                    end else if (soft_trig) begin
                        next_state = psq_pkg::PSQ_SOFT_HOLD;
                    end
                end
                psq_pkg::PSQ_HARD_HOLD: begin
                    if (at_last) begin
                        next_state = psq_pkg::PSQ_RUN;
                    end
                end
                psq_pkg::PSQ_SOFT_HOLD: begin
                    if (hard_trig) begin
                        next_state = psq_pkg::PSQ_HARD_HOLD;
                    end else if (at_last) begin
                        next_state = psq_pkg::PSQ_RUN;
                    end
                end
                default: next_state = psq_pkg::PSQ_POR_HOLD;
            endcase
        end
    end

    always_comb begin
        case (state)
            psq_pkg::PSQ_POR_WAIT: limit = `PSQ_CNT_W'(`PSQ_POR_TO_HARD_CYC); // RL4
            psq_pkg::PSQ_HARD_HOLD: limit = `PSQ_CNT_W'(`PSQ_HARD_HOLD_CYC);
            psq_pkg::PSQ_SOFT_HOLD: limit = `PSQ_CNT_W'(`PSQ_SOFT_HOLD_CYC);
            default: limit = `PSQ_CNT_W'(1);
        endcase
    end

    psq_cycle_counter u_counter (
        .clock(clock),
        .rst_b(rst_b),
        .restart(next_state != state), // RL10
        .limit(limit),
        .at_last(at_last)
    );

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= psq_pkg::PSQ_POR_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // Reset outputs follow the next state so they leave flops on the same edge.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hard_reset_out <= 1'b0;
            hard_reset_oe <= 1'b1;
            pll_reset_n <= 1'b0;
            core_reset_n <= 1'b0;
            periph_reset_n <= 1'b0;
            soft_reset_n <= 1'b1;
        end else begin
            hard_reset_out <= 1'b0; // RL8
            hard_reset_oe <= (next_state == psq_pkg::PSQ_POR_HOLD)
                | (next_state == psq_pkg::PSQ_POR_WAIT)
                | (next_state == psq_pkg::PSQ_HARD_HOLD); // RL6
            pll_reset_n <= (next_state != psq_pkg::PSQ_POR_HOLD); // RL6
            core_reset_n <= (next_state == psq_pkg::PSQ_RUN); // RL6
            periph_reset_n <= (next_state == psq_pkg::PSQ_RUN); // RL6
            soft_reset_n <= (next_state != psq_pkg::PSQ_SOFT_HOLD);
        end
    end

    // Straps are caught on the first cycle the power-on input reads high.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            boot_straps <= '0;
        end else if (state == psq_pkg::PSQ_POR_HOLD && power_on_reset_n) begin
            boot_straps <= strap_pins; // RL3 RL7
        end
    end

    // The host port wins when both loaders offer a word in the same cycle.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reset_config <= `PSQ_CFG_WORD_RESET;
            cfg_from_host <= 1'b0;
            cfg_from_i2c <= 1'b0;
        end else if (!power_on_reset_n) begin
            reset_config <= `PSQ_CFG_WORD_RESET; // RL1
            cfg_from_host <= 1'b0;
            cfg_from_i2c <= 1'b0;
        end else if (state == psq_pkg::PSQ_POR_WAIT) begin
            if (host_cfg_valid) begin
                reset_config <= host_cfg_word; // RL5 RL7
                cfg_from_host <= 1'b1;
                cfg_from_i2c <= 1'b0;
            end else if (i2c_cfg_valid) begin
                reset_config <= i2c_cfg_word; // RL5 RL7
                cfg_from_host <= 1'b0;
                cfg_from_i2c <= 1'b1;
            end
        end
    end

    always_comb begin
        cause_set = '0;
        if (state != psq_pkg::PSQ_HARD_HOLD && next_state == psq_pkg::PSQ_HARD_HOLD) begin
            cause_set.ext_hard = ~hard_reset_in;
            cause_set.watchdog = watchdog_expired;
            cause_set.bus_monitor = bus_monitor_expired;
            cause_set.sw_hard = control[`PSQ_CTRL_HARD_BIT];
        end else if (state == psq_pkg::PSQ_RUN && next_state == psq_pkg::PSQ_SOFT_HOLD) begin
            cause_set.jtag_soft = jtag_soft_req;
            cause_set.sw_soft = control[`PSQ_CTRL_SOFT_BIT];
        end
    end

    assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
    assign wr_sel = psq_reg_sel(aw_addr);
    assign wr_low = wr_fire & w_strb[0];

    // A new cause replaces the record; a set in the clear cycle survives it.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cause <= `PSQ_CAUSE_RESET;
        end else if (!power_on_reset_n) begin
            cause <= `PSQ_CAUSE_RESET; // RL9
        end else if (cause_set != '0) begin
            cause <= cause_set; // RL9
        end else if (wr_low && wr_sel == 3'h0) begin
            cause <= cause & ~w_data[6:0];
        end
    end

    // Request bits clear themselves when their flow begins.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            control <= `PSQ_CTRL_RESET;
        end else if (!power_on_reset_n) begin
            control <= `PSQ_CTRL_RESET; // RL1
        end else if (wr_low && wr_sel == 3'h3) begin
            control <= w_data[1:0];
        end else if (next_state == psq_pkg::PSQ_HARD_HOLD) begin
            control <= `PSQ_CTRL_RESET;
        end else if (next_state == psq_pkg::PSQ_SOFT_HOLD) begin
            control[`PSQ_CTRL_SOFT_BIT] <= 1'b0;
        end
    end

    // Write channel: address and data are taken in either order.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PSQ_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_sel == 3'h0 || wr_sel == 3'h3) ? `PSQ_RESP_OKAY
                    : `PSQ_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel: one read at a time, answered on the edge after the address.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PSQ_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `PSQ_RESP_OKAY;
            case (psq_reg_sel(s_axi_araddr))
                3'h0: s_axi_rdata <= {25'h0, cause};
                3'h1: s_axi_rdata <= {27'h0, boot_straps};
                3'h2: s_axi_rdata <= {14'h0, cfg_from_i2c, cfg_from_host, reset_config};
                3'h3: s_axi_rdata <= {30'h0, control};
                3'h4: s_axi_rdata <= {29'h0, state};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `PSQ_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // psq_sequencer

`default_nettype wire

// File: logic/psq_cfg.svh
// Constants of the power-on reset and configuration sequencer.
// Assumes a single 20 MHz clock; all reset timings are counted in its cycles.
`ifndef PSQ_CFG_SVH
`define PSQ_CFG_SVH

// Times are given in input clock cycles, so one clock of time is one cycle.
`define PSQ_CLOCK_HZ 20000000
`define PSQ_POR_MIN_CLKS 16
`define PSQ_POR_TO_HARD_CLKS 521
`define PSQ_POR_TO_HARD_CYC (`PSQ_POR_TO_HARD_CLKS * 1)
`define PSQ_HARD_HOLD_CLKS 16
`define PSQ_HARD_HOLD_CYC (`PSQ_HARD_HOLD_CLKS * 1)
`define PSQ_SOFT_HOLD_CLKS 16
`define PSQ_SOFT_HOLD_CYC (`PSQ_SOFT_HOLD_CLKS * 1)
`define PSQ_CNT_W 10

// Register byte offsets.
`define PSQ_REG_CAUSE 8'h00
`define PSQ_REG_STRAPS 8'h04
`define PSQ_REG_CONFIG 8'h08
`define PSQ_REG_CONTROL 8'h0c
`define PSQ_REG_STATE 8'h10

// Field positions.
`define PSQ_CFG_FROM_HOST_BIT 16
`define PSQ_CFG_FROM_I2C_BIT 17
`define PSQ_CTRL_HARD_BIT 0
`define PSQ_CTRL_SOFT_BIT 1

// Reset values.
`define PSQ_CAUSE_RESET 7'h01
`define PSQ_CTRL_RESET 2'h0
`define PSQ_CFG_WORD_RESET 16'h0000

// Bus answers.
`define PSQ_RESP_OKAY 2'h0
`define PSQ_RESP_SLVERR 2'h2

`endif

// File: logic/psq_pkg.sv
// Types shared by the reset sequencer, its bound checker and its testbench.
// Assumes the constants header is on the include path.
`default_nettype none
`include "psq_cfg.svh"

package psq_pkg;

    typedef enum logic [2:0] {
        PSQ_POR_HOLD = 3'b000,
        PSQ_POR_WAIT = 3'b001,
        PSQ_RUN = 3'b010,
        PSQ_HARD_HOLD = 3'b011,
        PSQ_SOFT_HOLD = 3'b100
    } psq_state_t;

    typedef struct packed {
        logic [1:0] boot_mode_select;
        logic watchdog_enable_strap;
        logic host_byte_width_strap;
        logic host_strobe_polarity_strap;
    } psq_straps_t;

    // Bit 0 is the lowest field, the power-on cause.
    typedef struct packed {
        logic sw_soft;
        logic sw_hard;
        logic jtag_soft;
        logic bus_monitor;
        logic watchdog;
        logic ext_hard;
        logic power_on;
    } psq_cause_t;

endpackage

`default_nettype wire

// File: logic/psq_cycle_counter.sv
// Cycle counter that marks the last cycle of a reset phase.
// Assumes the caller pulses restart on every phase change.
`timescale 1ns/1ns
`default_nettype none
`include "psq_cfg.svh"

module psq_cycle_counter (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic restart,
    input wire logic [`PSQ_CNT_W-1:0] limit,
    output logic at_last
);

    logic [`PSQ_CNT_W-1:0] count;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (restart) begin
            count <= '0; // RL10
        end else if (!at_last) begin
            count <= count + `PSQ_CNT_W'(1);
        end
    end

    // The count holds at its last value so a stalled phase does not wrap.
    assign at_last = (count == limit - `PSQ_CNT_W'(1));

endmodule // psq_cycle_counter

`default_nettype wire

// File: test/psq_sequencer_assertions.sv
// Concurrent checks on the pins of the reset sequencer.
// Assumes it is bound into psq_sequencer and that all pin inputs are synchronous.
`timescale 1ns/1ns
`default_nettype none
module psq_sequencer_assertions (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic power_on_reset_n,
    input wire psq_pkg::psq_straps_t strap_pins,
    input wire logic hard_reset_in,
    input wire logic hard_reset_oe,
    input wire logic hard_reset_out,
    input wire logic watchdog_expired,
    input wire logic bus_monitor_expired,
    input wire logic jtag_soft_req,
    input wire logic pll_reset_n,
    input wire logic core_reset_n,
    input wire logic periph_reset_n,
    input wire logic soft_reset_n,
    input wire psq_pkg::psq_straps_t boot_straps
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Saturates, so a long run never wraps back into the release window.
    logic [9:0] since_por;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            since_por <= 10'h000;
        end else if (!power_on_reset_n) begin
            since_por <= 10'h000;
        end else if (since_por != 10'h3ff) begin
            since_por <= since_por + 10'h001;
        end
    end
    a_por_drives_all: assert property (!power_on_reset_n |=> hard_reset_oe && !core_reset_n
        && !periph_reset_n && !pll_reset_n) else $error("power-on reset outputs wrong");
    a_release_wait: assert property (since_por >= 10'h001 && since_por <= 10'h209 |->
        hard_reset_oe && pll_reset_n) else $error("hard reset released early");
    a_release_edge: assert property (since_por == 10'h20a |-> !hard_reset_oe && core_reset_n
        && periph_reset_n) else $error("hard reset not released on time");
    a_strap_capture: assert property ($rose(power_on_reset_n) |=>
        boot_straps == $past(strap_pins)) else $error("straps not captured");
    a_straps_held: assert property ($changed(boot_straps) |-> $past(power_on_reset_n)
        && !$past(power_on_reset_n, 2)) else $error("straps resampled");
    a_hard_entry: assert property (core_reset_n && power_on_reset_n && (watchdog_expired
        || bus_monitor_expired || !hard_reset_in) |=> hard_reset_oe && !core_reset_n)
        else $error("hard flow not started");
    a_hard_hold: assert property ($rose(hard_reset_oe) && $past(power_on_reset_n) |->
        hard_reset_oe [*8]) else $error("hard reset pulse too short");
    a_soft_entry: assert property (core_reset_n && power_on_reset_n && hard_reset_in
        && jtag_soft_req && !watchdog_expired && !bus_monitor_expired |=> !soft_reset_n
        && !hard_reset_oe) else $error("soft flow wrong");
    a_soft_quiet: assert property (!soft_reset_n |-> !hard_reset_oe && pll_reset_n)
        else $error("soft reset touched hard or pll");
    a_open_drain_low: assert property (hard_reset_oe |-> !hard_reset_out)
        else $error("hard reset pin driven high");
    c_full_release: cover property (since_por == 10'h20a);
    c_hard_flow: cover property ($rose(hard_reset_oe) && power_on_reset_n);
    c_soft_flow: cover property ($fell(soft_reset_n));
endmodule // psq_sequencer_assertions
bind psq_sequencer psq_sequencer_assertions i_chk (.*);
`default_nettype wire

// File: test/psq_supervisor.sv
// Model of the outside supervisor and the pulled-up hard reset wire.
// Assumes por_go and ext_pull change just after rising edges.
`timescale 1ns/1ns
`default_nettype none
module psq_supervisor (
    input wire logic clock,
    input wire logic por_go,
    input wire logic [9:0] por_len,
    input wire logic ext_pull,
    input wire logic hard_reset_oe,
    output logic power_on_reset_n,
    output logic hard_reset_in
);
    int hold = 20;
    // A request below the minimum is stretched, so the device never sees a short pulse.
    always @(posedge clock) begin
        if (por_go) begin
            hold <= (por_len < 10'h010) ? 16 : int'(por_len);
        end else if (hold != 0) begin
            hold <= hold - 1;
        end
    end
    assign power_on_reset_n = (hold == 0);
    // Open drain with a pull-up: the wire is low while either party pulls it.
    assign hard_reset_in = !(hard_reset_oe || ext_pull);
endmodule // psq_supervisor
`default_nettype wire

// File: test/psq_sequencer_test.sv
// Self-checking bench: power-on timing, straps, config words, reset flows, registers.
// Assumes the supervisor model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
`include "psq_cfg.svh"
module psq_sequencer_test;
    logic clock = 1'b0, rst_b = 1'b0, por_go = 1'b0, ext_pull = 1'b0;
    logic [9:0] por_len = 10'h010;
    logic power_on_reset_n, hard_reset_in, hard_reset_out, hard_reset_oe;
    logic watchdog_expired = 1'b0, bus_monitor_expired = 1'b0, jtag_soft_req = 1'b0;
    logic host_cfg_valid = 1'b0, i2c_cfg_valid = 1'b0;
    logic [15:0] host_cfg_word = 16'h0000, i2c_cfg_word = 16'h0000, reset_config;
    logic pll_reset_n, core_reset_n, periph_reset_n, soft_reset_n;
    psq_pkg::psq_straps_t strap_pins = 5'h00, boot_straps;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, s, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] seed = 32'h46;
    logic [4:0] es;
    int num_errors = 0, checks = 0, cyc = 0, n;
    int cause_bit[6] = '{2, 3, 1, 4, 5, 6};
    psq_sequencer i_dut (.*);
    psq_supervisor i_sup (.*);
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            num_errors++;
            report_and_stop();
        end
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task report_and_stop();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(ta && tw)) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready === 1'b1) ta = 1'b1;
            if (s_axi_wvalid && s_axi_wready === 1'b1) tw = 1'b1;
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1) @(posedge clock);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge clock);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        rd(a, d, r);
        chk({30'h0, r}, {30'h0, `PSQ_RESP_OKAY});
        chk(d, e);
    endtask
    // Starts a power-on reset, hands in one config word mid-wait, and counts release cycles.
    task por_run(input int stop_at, input logic sel, input int exp_n);
        s = rnd();
        es = s[4:0];
        strap_pins <= s[4:0];
        por_len <= {5'h00, s[9:5]} + 10'h010;
        host_cfg_word <= s[31:16];
        i2c_cfg_word <= s[31:16];
        n = 0;
        @(posedge clock);
        por_go <= 1'b1;
        @(posedge clock);
        por_go <= 1'b0;
        while (power_on_reset_n !== 1'b0) @(posedge clock);
        while (power_on_reset_n !== 1'b1) @(posedge clock);
        do begin
            @(posedge clock);
            n++;
            {host_cfg_valid, i2c_cfg_valid} <= (n == 5) ? {!sel, sel} : 2'h0;
        end while (hard_reset_oe !== 1'b0 && n != stop_at);
        chk(n, exp_n);
        chk({27'h0, boot_straps}, {27'h0, es});
        chk({16'h0, reset_config}, {16'h0, s[31:16]});
        rdchk(`PSQ_REG_CONFIG, (32'h1 << (`PSQ_CFG_FROM_HOST_BIT + sel)) | s[31:16]);
        rdchk(`PSQ_REG_CAUSE, 32'h1);
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        por_run(0, 1'b0, 522);
        for (int i = 0; i < 6; i++) begin
            strap_pins <= ~strap_pins;
            @(posedge clock);
            case (i)
                0: watchdog_expired <= 1'b1;
                1: bus_monitor_expired <= 1'b1;
                2: ext_pull <= 1'b1;
                3: jtag_soft_req <= 1'b1;
                4: wr(`PSQ_REG_CONTROL, 32'h1, r);
                default: wr(`PSQ_REG_CONTROL, 32'h2, r);
            endcase
            @(posedge clock);
            {watchdog_expired, bus_monitor_expired, ext_pull, jtag_soft_req} <= 4'h0;
            repeat (2) @(posedge clock);
            while (core_reset_n !== 1'b1 || soft_reset_n !== 1'b1) @(posedge clock);
            rdchk(`PSQ_REG_CAUSE, 32'h1 << cause_bit[i]);
            wr(`PSQ_REG_CAUSE, 32'h7f, r);
            rdchk(`PSQ_REG_CAUSE, 32'h0);
            chk({27'h0, boot_straps}, {27'h0, es});
        end
        rd(8'h20, d, r);
        chk({30'h0, r}, {30'h0, `PSQ_RESP_SLVERR});
        wr(`PSQ_REG_STRAPS, 32'h0, r);
        chk({30'h0, r}, {30'h0, `PSQ_RESP_SLVERR});
        rdchk(`PSQ_REG_STRAPS, {27'h0, es});
        rdchk(`PSQ_REG_CONTROL, 32'h0);
        rdchk(`PSQ_REG_STATE, 32'h2);
        por_run(300, 1'b1, 300);
        por_run(0, 1'b1, 522);
        report_and_stop();
    end
endmodule // psq_sequencer_test
`default_nettype wire
